// ===== clb_pkg.sv
// shared constants and types for the charger led and isolation switch config bank
// assumes a single 40 MHz clock and an external serial controller driving reg_req
package clb_pkg;

  // clock
  localparam int CLK_HZ = 40_000_000;

  // register byte addresses
  localparam logic [7:0] ADDR_SUPPLY_CMP   = 8'h1B;
  localparam logic [7:0] ADDR_DUTY_CTL     = 8'h1C;
  localparam logic [7:0] ADDR_FAULT_POLICY = 8'h1D;
  localparam logic [7:0] ADDR_INDICATOR_BLINK_PATTERN      = 8'h1E;
  localparam logic [7:0] ADDR_KEY_RSVD     = 8'h1F;
  localparam logic [7:0] RST_BYTE          = 8'h00;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // supply compare fields
  localparam int SC_DEB_LSB = 0;
  localparam int SC_DEB_MSB = 1;
  localparam int SC_THR_BIT = 2;

  // duty control fields
  localparam int DUTY_LSB = 0;
  localparam int DUTY_MSB = 5;
  localparam int RAMP_BIT = 6;
  localparam int DRV_BIT  = 7;

  // fault policy fields
  localparam int KEEP_OV_BIT    = 0;
  localparam int KEEP_WD_BIT    = 1;
  localparam int KEEP_THERM_BIT = 2;
  localparam int KEEP_SHDN_BIT  = 3;
  localparam int KEEP_TMR_BIT   = 4;

  // indicator config fields
  localparam int FREQ_LSB  = 0;
  localparam int FREQ_MSB  = 1;
  localparam int CUR_LSB   = 2;
  localparam int CUR_MSB   = 3;
  localparam int BLINK_BIT = 4;
  localparam int OVRD_BIT  = 5;

  // debounce codes and times
  localparam logic [1:0] DEB_RSVD  = 2'h0;
  localparam logic [1:0] DEB_100US = 2'h1;
  localparam logic [1:0] DEB_1MS   = 2'h2;
  localparam logic [1:0] DEB_10MS  = 2'h3;
  localparam int DEB_SHORT_US = 100;
  localparam int DEB_MID_MS   = 1;
  localparam int DEB_LONG_MS  = 10;
  localparam int DEB_SHORT_CYC = (CLK_HZ / 1_000_000) * DEB_SHORT_US;
  localparam int DEB_MID_CYC   = (CLK_HZ / 1_000) * DEB_MID_MS;
  localparam int DEB_LONG_CYC  = (CLK_HZ / 1_000) * DEB_LONG_MS;
  localparam int DEB_W         = 19;

  // indicator frequency codes and rates in millihertz
  localparam logic [1:0] FREQ_1HZ   = 2'h0;
  localparam logic [1:0] FREQ_0P5HZ = 2'h1;
  localparam logic [1:0] FREQ_256HZ = 2'h2;
  localparam logic [1:0] FREQ_8HZ   = 2'h3;
  localparam int RATE_1HZ_MHZ   = 1_000;
  localparam int RATE_0P5HZ_MHZ = 500;
  localparam int RATE_256HZ_MHZ = 256_000;
  localparam int RATE_8HZ_MHZ   = 8_000;
  localparam int SLOTS          = 32;
  localparam int SLOT_1HZ_CYC   = (CLK_HZ / SLOTS) * 1000 / RATE_1HZ_MHZ;
  localparam int SLOT_0P5HZ_CYC = (CLK_HZ / SLOTS) * 1000 / RATE_0P5HZ_MHZ;
  localparam int SLOT_256HZ_CYC = (CLK_HZ / SLOTS) * 1000 / RATE_256HZ_MHZ;
  localparam int SLOT_8HZ_CYC   = (CLK_HZ / SLOTS) * 1000 / RATE_8HZ_MHZ;
  localparam int SLOT_W         = 22;

  // duty values
  localparam logic [5:0] DUTY_FULL  = 6'h20;
  localparam logic [5:0] FLASH_DUTY = 6'h10;
  localparam logic [4:0] SLOT_LAST  = 5'h1F;

  // led source while the charger state machine owns the led
  typedef enum logic [2:0] {
    LED_OFF    = 3'b001,
    LED_STEADY = 3'b010,
    LED_FLASH  = 3'b100
  } clb_led_mode_t;

  typedef struct packed {
    logic overvoltage;
    logic watchdog;
    logic thermistor;
    logic shutdown;
    logic timer;
  } clb_fault_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } clb_reg_req_t;

endpackage : clb_pkg

// ===== clb_pwm.sv
// 32-slot indicator pwm generator with optional duty ramp
// assumes slot_cycles_in is at least one and steady between periods
`timescale 1ns/1ps

module clb_pwm #(
  parameter int SLOT_W = 22
) (
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_in,
  // settings
  input  wire logic [SLOT_W-1:0] slot_cycles_in,
  input  wire logic [5:0]        duty_in,
  input  wire logic              ramp_in,
  input  wire logic              enable_in,
  // result
  output logic                   pwm_out,
  output logic [5:0]             eff_duty_out
);
  import clb_pkg::*;

  logic [SLOT_W-1:0] slot_cnt_ff;
  logic [4:0]        slot_idx_ff;
  logic [5:0]        eff_ff;
  logic              out_ff;
  logic [5:0]        target;
  logic              slot_end;
  logic              period_end;

  // anything from 32 upward is full on-time
  function automatic logic [5:0] clamp_duty(input logic [5:0] d);
    clamp_duty = (d >= DUTY_FULL) ? DUTY_FULL : d;
  endfunction : clamp_duty

  assign target     = clamp_duty(duty_in);
  // >= so a shorter period picked mid-slot cannot overrun the counter
  assign slot_end   = (slot_cnt_ff >= slot_cycles_in - SLOT_W'(1));
  assign period_end = slot_end && (slot_idx_ff == SLOT_LAST);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      slot_cnt_ff <= '0;
      slot_idx_ff <= '0;
    end else if (slot_end) begin
      slot_cnt_ff <= '0;
      slot_idx_ff <= slot_idx_ff + 5'h01;
    end else begin
      slot_cnt_ff <= slot_cnt_ff + SLOT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      eff_ff <= '0;
    end else if (!ramp_in) begin
      eff_ff <= target;
    end else if (period_end) begin
      if (eff_ff < target) begin
        eff_ff <= eff_ff + 6'h01;
      end else if (eff_ff > target) begin
        eff_ff <= eff_ff - 6'h01;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= enable_in && ({1'b0, slot_idx_ff} < eff_ff);
    end
  end

  assign pwm_out      = out_ff;
  assign eff_duty_out = eff_ff;

endmodule : clb_pwm

// ===== clb_config_bank.sv
// charger configuration bank: supply compare, indicator led, isolation switch policy
// assumes a serial controller on the same clock presents one-cycle wr/rd strobes,
// fault and charger state inputs are synchronous, the comparator input is not
`timescale 1ns/1ps

// What this block does
// - debounce code picks 100us, 1ms or 10ms
// - threshold bit selects 50 or 175 mV
// - duty field gives on-time value/32, capped
// - duty bit 6 enables pwm ramping
// - overvoltage opens switch unless bit 0 set
// - watchdog fault opens switch unless bit 1
// - thermistor fault opens switch unless bit 2
// - thermal shutdown opens switch unless bit 3
// - timer fault bit 4, cleared only by power-on
// - frequency code picks 1, 0.5, 256, 8 Hz
// - current field, only code 1 valid
// - pattern 0: steady charging, flash fault, done off
// - pattern 1: flash charging, steady fault, done off
// - override hands led to software settings
// - fields clear to zero on core reset, except timer bit 4
module clb_config_bank #(
  parameter int DEB_MID_CYCLES   = clb_pkg::DEB_MID_CYC,
  parameter int DEB_LONG_CYCLES  = clb_pkg::DEB_LONG_CYC,
  parameter int SLOT_1HZ_CYCLES  = clb_pkg::SLOT_1HZ_CYC,
  parameter int SLOT_HALF_CYCLES = clb_pkg::SLOT_0P5HZ_CYC,
  parameter int SLOT_256_CYCLES  = clb_pkg::SLOT_256HZ_CYC,
  parameter int SLOT_8HZ_CYCLES  = clb_pkg::SLOT_8HZ_CYC
) (
  // clock and resets
  input  wire logic           mclk_in,
  input  wire logic           rst_in,
  input  wire logic           por_rst_in,
  // register port
  input  clb_pkg::clb_reg_req_t reg_req_in,
  output logic [7:0]          reg_rdata_out,
  output logic                reg_rvalid_out,
  // supply versus system rail comparator
  input  wire logic           supply_cmp_raw_in,
  output logic                supply_cmp_out,
  output logic [1:0]          supply_compare_debounce_out,
  output logic                supply_compare_threshold_out,
  // battery isolation switch
  input  clb_pkg::clb_fault_t fault_in,
  output logic                battery_isolation_switch_open_out,
  // indicator led
  input  wire logic           charging_in,
  input  wire logic           charger_fault_in,
  input  wire logic           charge_done_in,
  output logic                indicator_led_out,
  output logic [1:0]          indicator_current_out
);
  import clb_pkg::*;

  logic              core_rst;
  logic [7:0]        supply_compare_config_ff;
  logic [7:0]        indicator_duty_control_ff;
  logic [3:0]        fault_policy_lo_ff;
  logic              timer_fault_keep_switch_closed_ff;
  logic [2:0]        fault_policy_hi_ff;
  logic [7:0]        indicator_config_ff;
  logic [7:0]        charger_key_reserved_ff;
  logic [7:0]        rdata_ff;
  logic              rvalid_ff;
  logic [7:0]        fault_policy;

  // power-on also clears everything the core reset clears
  assign core_rst = rst_in | por_rst_in;

  function automatic logic write_hit(input clb_reg_req_t r, input logic [7:0] a);
    write_hit = r.wr && (r.addr == a);
  endfunction : write_hit

  assign fault_policy = {fault_policy_hi_ff, timer_fault_keep_switch_closed_ff,
                         fault_policy_lo_ff};

  ////////////////////////////////////////////////////////////////////////////
  // register file
  always_ff @(posedge mclk_in) begin
    if (core_rst) begin
      supply_compare_config_ff <= RST_BYTE;
    end else if (write_hit(reg_req_in, ADDR_SUPPLY_CMP)) begin
      supply_compare_config_ff <= reg_req_in.wdata;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (core_rst) begin
      indicator_duty_control_ff <= RST_BYTE;
    end else if (write_hit(reg_req_in, ADDR_DUTY_CTL)) begin
      indicator_duty_control_ff <= reg_req_in.wdata;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (core_rst) begin
      fault_policy_lo_ff <= RST_BYTE[KEEP_SHDN_BIT:KEEP_OV_BIT];
      fault_policy_hi_ff <= RST_BYTE[7:KEEP_TMR_BIT+1];
    end else if (write_hit(reg_req_in, ADDR_FAULT_POLICY)) begin
      fault_policy_lo_ff <= reg_req_in.wdata[KEEP_SHDN_BIT:KEEP_OV_BIT];
      fault_policy_hi_ff <= reg_req_in.wdata[7:KEEP_TMR_BIT+1];
    end
  end

  // survives the core reset on purpose; only power-on clears it
  always_ff @(posedge mclk_in) begin
    if (por_rst_in) begin
      timer_fault_keep_switch_closed_ff <= RST_BYTE[KEEP_TMR_BIT];
    end else if (write_hit(reg_req_in, ADDR_FAULT_POLICY)) begin
      timer_fault_keep_switch_closed_ff <= reg_req_in.wdata[KEEP_TMR_BIT];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (core_rst) begin
      indicator_config_ff <= RST_BYTE;
    end else if (write_hit(reg_req_in, ADDR_INDICATOR_BLINK_PATTERN)) begin
      indicator_config_ff <= reg_req_in.wdata;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (core_rst) begin
      charger_key_reserved_ff <= RST_BYTE;
    end else if (write_hit(reg_req_in, ADDR_KEY_RSVD)) begin
      charger_key_reserved_ff <= reg_req_in.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, answer one cycle after the strobe
  always_ff @(posedge mclk_in) begin
    if (core_rst) begin
      rdata_ff  <= RST_BYTE;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_req_in.rd;
      if (reg_req_in.rd) begin
        case (reg_req_in.addr)
          ADDR_SUPPLY_CMP:   rdata_ff <= supply_compare_config_ff;
          ADDR_DUTY_CTL:     rdata_ff <= indicator_duty_control_ff;
          ADDR_FAULT_POLICY: rdata_ff <= fault_policy;
          ADDR_INDICATOR_BLINK_PATTERN:      rdata_ff <= indicator_config_ff;
          ADDR_KEY_RSVD:     rdata_ff <= charger_key_reserved_ff;
          default:           rdata_ff <= UNMAPPED_READ;
        endcase
      end
    end
  end

  assign reg_rdata_out  = rdata_ff;
  assign reg_rvalid_out = rvalid_ff;

  ////////////////////////////////////////////////////////////////////////////
  // comparator settings and debounce
  logic             cmp_sync1_ff;
  logic             cmp_sync2_ff;
  logic             cmp_ff;
  logic [DEB_W-1:0] deb_cnt_ff;
  logic [DEB_W-1:0] deb_limit;
  logic             deb_valid;
  logic [1:0]       deb_code;

  assign deb_code                     = supply_compare_config_ff[SC_DEB_MSB:SC_DEB_LSB];
  assign supply_compare_debounce_out  = deb_code;
  assign supply_compare_threshold_out = supply_compare_config_ff[SC_THR_BIT];

  always_comb begin
    deb_valid = 1'b1;
    case (deb_code)
      DEB_100US: deb_limit = DEB_W'(DEB_SHORT_CYC);
      DEB_1MS:   deb_limit = DEB_W'(DEB_MID_CYCLES);
      DEB_10MS:  deb_limit = DEB_W'(DEB_LONG_CYCLES);
      default: begin
        // reserved code freezes the filtered output rather than guess a time
        deb_limit = DEB_W'(DEB_SHORT_CYC);
        deb_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (core_rst) begin
      cmp_sync1_ff <= 1'b0;
      cmp_sync2_ff <= 1'b0;
    end else begin
      cmp_sync1_ff <= supply_cmp_raw_in;
      cmp_sync2_ff <= cmp_sync1_ff;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (core_rst) begin
      deb_cnt_ff <= '0;
      cmp_ff     <= 1'b0;
    end else if (!deb_valid || (cmp_sync2_ff == cmp_ff)) begin
      deb_cnt_ff <= '0;
    end else if (deb_cnt_ff >= deb_limit - DEB_W'(1)) begin
      deb_cnt_ff <= '0;
      cmp_ff     <= cmp_sync2_ff;
    end else begin
      deb_cnt_ff <= deb_cnt_ff + DEB_W'(1);
    end
  end

  assign supply_cmp_out = cmp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // battery isolation switch policy
  logic iso_open_ff;

  always_ff @(posedge mclk_in) begin
    if (core_rst) begin
      iso_open_ff <= 1'b0;
    end else begin
      iso_open_ff <= (fault_in.overvoltage && !fault_policy[KEEP_OV_BIT])
                  || (fault_in.watchdog    && !fault_policy[KEEP_WD_BIT])
                  || (fault_in.thermistor  && !fault_policy[KEEP_THERM_BIT])
                  || (fault_in.shutdown    && !fault_policy[KEEP_SHDN_BIT])
                  || (fault_in.timer       && !fault_policy[KEEP_TMR_BIT]);
    end
  end

  assign battery_isolation_switch_open_out = iso_open_ff;

  ////////////////////////////////////////////////////////////////////////////
  // indicator led
  logic              sw_override;
  logic              blink_pattern;
  logic [1:0]        freq_code;
  logic [SLOT_W-1:0] slot_cycles;
  logic [5:0]        pwm_duty;
  logic              pwm_ramp;
  logic              pwm_enable;
  logic              pwm_level;
  logic              led_ff;
  clb_led_mode_t     led_mode;

  assign sw_override   = indicator_config_ff[OVRD_BIT];
  assign blink_pattern = indicator_config_ff[BLINK_BIT];
  assign freq_code     = indicator_config_ff[FREQ_MSB:FREQ_LSB];
  // reserved current codes pass through; software must not pick them
  assign indicator_current_out = indicator_config_ff[CUR_MSB:CUR_LSB];

  always_comb begin
    case (freq_code)
      FREQ_1HZ:   slot_cycles = SLOT_W'(SLOT_1HZ_CYCLES);
      FREQ_0P5HZ: slot_cycles = SLOT_W'(SLOT_HALF_CYCLES);
      FREQ_256HZ: slot_cycles = SLOT_W'(SLOT_256_CYCLES);
      FREQ_8HZ:   slot_cycles = SLOT_W'(SLOT_8HZ_CYCLES);
      default:    slot_cycles = SLOT_W'(SLOT_1HZ_CYCLES);
    endcase
  end

  // done wins, then fault, then charging
  always_comb begin
    if (charge_done_in) begin
      led_mode = LED_OFF;
    end else if (charger_fault_in) begin
      led_mode = blink_pattern ? LED_STEADY : LED_FLASH;
    end else if (charging_in) begin
      led_mode = blink_pattern ? LED_FLASH : LED_STEADY;
    end else begin
      led_mode = LED_OFF;
    end
  end

  // one generator serves both owners; flashing uses half duty at the set rate
  assign pwm_duty   = sw_override ? indicator_duty_control_ff[DUTY_MSB:DUTY_LSB]
                                  : FLASH_DUTY;
  assign pwm_ramp   = sw_override && indicator_duty_control_ff[RAMP_BIT];
  assign pwm_enable = !sw_override || indicator_duty_control_ff[DRV_BIT];

  clb_pwm #(
    .SLOT_W (SLOT_W)
  ) u_pwm (
    .mclk_in        (mclk_in),
    .rst_in         (core_rst),
    .slot_cycles_in (slot_cycles),
    .duty_in        (pwm_duty),
    .ramp_in        (pwm_ramp),
    .enable_in      (pwm_enable),
    .pwm_out        (pwm_level),
    .eff_duty_out   ()
  );

  always_ff @(posedge mclk_in) begin
    if (core_rst) begin
      led_ff <= 1'b0;
    end else if (sw_override) begin
      led_ff <= pwm_level;
    end else begin
      case (led_mode)
        LED_OFF:    led_ff <= 1'b0;
        LED_STEADY: led_ff <= 1'b1;
        LED_FLASH:  led_ff <= pwm_level;
        default:    led_ff <= 1'b0;
      endcase
    end
  end

  assign indicator_led_out = led_ff;

endmodule : clb_config_bank

// ===== clb_host.sv
// host model driving the config bank register strobe port
// assumes the bench calls wr and rd from one process at a time
`timescale 1ns/1ps

module clb_host
  import clb_pkg::*;
(
  // clock
  input  wire logic             mclk_in,
  // request and answer
  output clb_pkg::clb_reg_req_t reg_req_out,
  input  wire logic [7:0]       reg_rdata_in,
  input  wire logic             reg_rvalid_in
);
  initial reg_req_out = '{addr: 8'hA5, wdata: 8'h5A, wr: 1'b0, rd: 1'b0};

  // released bus shows the inverse, never a stale copy
  task automatic idle();
    reg_req_out = '{addr: ~reg_req_out.addr, wdata: ~reg_req_out.wdata, wr: 1'b0, rd: 1'b0};
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    #2;
    reg_req_out = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    #2;
    idle();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n = 0;
    @(posedge mclk_in);
    #2;
    reg_req_out = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    #2;
    idle();
    while (reg_rvalid_in !== 1'b1 && n < 4) begin
      @(posedge mclk_in);
      #2;
      n++;
    end
    d = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 8'hXX;
  endtask : rd
endmodule : clb_host

// ===== clb_config_bank_asserts.sv
// port checker for the charger config bank
// assumes one clock; policy, override and enable bits shadowed from writes
`timescale 1ns/1ps

module clb_config_bank_asserts
  import clb_pkg::*;
(
  // clock and resets
  input wire logic             mclk_in,
  input wire logic             rst_in,
  input wire logic             por_rst_in,
  // observed ports
  input clb_pkg::clb_reg_req_t reg_req_in,
  input wire logic             reg_rvalid_out,
  input wire logic [1:0]       supply_compare_debounce_out,
  input wire logic             supply_compare_threshold_out,
  input clb_pkg::clb_fault_t   fault_in,
  input wire logic             battery_isolation_switch_open_out,
  input wire logic             charge_done_in,
  input wire logic             indicator_led_out,
  input wire logic [1:0]       indicator_current_out
);
  logic [4:0] keep_ff;
  logic       ovrd_ff;
  logic       drv_ff;
  logic       wr_ok;
  logic [4:0] hit;
  assign wr_ok = reg_req_in.wr && !rst_in && !por_rst_in;
  assign hit = fault_in & ~{keep_ff[0], keep_ff[1], keep_ff[2], keep_ff[3], keep_ff[4]};

  // timer bit outlives core reset, so the shadow must too
  always_ff @(posedge mclk_in) begin
    if (por_rst_in) keep_ff <= 5'h00;
    else if (rst_in) keep_ff <= {keep_ff[4], 4'h0};
    else if (wr_ok && reg_req_in.addr == ADDR_FAULT_POLICY) keep_ff <= reg_req_in.wdata[4:0];
  end
  always_ff @(posedge mclk_in) begin
    if (rst_in || por_rst_in) ovrd_ff <= 1'b0;
    else if (wr_ok && reg_req_in.addr == ADDR_INDICATOR_BLINK_PATTERN) ovrd_ff <= reg_req_in.wdata[OVRD_BIT];
  end
  always_ff @(posedge mclk_in) begin
    if (rst_in || por_rst_in) drv_ff <= 1'b0;
    else if (wr_ok && reg_req_in.addr == ADDR_DUTY_CTL) drv_ff <= reg_req_in.wdata[DRV_BIT];
  end

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in || por_rst_in);

  ov_opens_a: assert property (hit[4] |=> battery_isolation_switch_open_out)
    else $error("overvoltage left switch closed");
  wd_opens_a: assert property (hit[3] |=> battery_isolation_switch_open_out)
    else $error("watchdog fault left switch closed");
  therm_opens_a: assert property (hit[2] |=> battery_isolation_switch_open_out)
    else $error("thermistor fault left switch closed");
  shdn_opens_a: assert property (hit[1] |=> battery_isolation_switch_open_out)
    else $error("shutdown left switch closed");
  tmr_opens_a: assert property (hit[0] |=> battery_isolation_switch_open_out)
    else $error("timer fault left switch closed");
  switch_kept_a: assert property (hit == 5'h00 |=> !battery_isolation_switch_open_out)
    else $error("switch opened without enabled fault");
  cmp_cfg_a: assert property (reg_req_in.wr && reg_req_in.addr == ADDR_SUPPLY_CMP |=>
    supply_compare_debounce_out == $past(reg_req_in.wdata[1:0]) &&
    supply_compare_threshold_out == $past(reg_req_in.wdata[SC_THR_BIT]))
    else $error("comparator settings not taken");
  cur_cfg_a: assert property (reg_req_in.wr && reg_req_in.addr == ADDR_INDICATOR_BLINK_PATTERN |=>
    indicator_current_out == $past(reg_req_in.wdata[3:2]))
    else $error("current setting not taken");
  core_clear_a: assert property (disable iff (por_rst_in) rst_in |=>
    supply_compare_debounce_out == 2'h0 && !supply_compare_threshold_out &&
    indicator_current_out == 2'h0 && !reg_rvalid_out)
    else $error("outputs not cleared by core reset");
  done_off_a: assert property ((charge_done_in && !ovrd_ff) [*4] |-> !indicator_led_out)
    else $error("led lit in done state");
  drv_off_a: assert property ((ovrd_ff && !drv_ff) [*4] |-> !indicator_led_out)
    else $error("led lit with driver disabled");
endmodule : clb_config_bank_asserts

bind clb_config_bank clb_config_bank_asserts CHK (
  .mclk_in(mclk_in), .rst_in(rst_in), .por_rst_in(por_rst_in), .reg_req_in(reg_req_in),
  .reg_rvalid_out(reg_rvalid_out), .supply_compare_debounce_out(supply_compare_debounce_out),
  .supply_compare_threshold_out(supply_compare_threshold_out), .fault_in(fault_in),
  .battery_isolation_switch_open_out(battery_isolation_switch_open_out),
  .charge_done_in(charge_done_in), .indicator_led_out(indicator_led_out),
  .indicator_current_out(indicator_current_out));

// ===== clb_config_bank_bench.sv
// self-checking bench for the charger config bank
// assumes shortened slot and debounce parameters set at the instance below
`timescale 1ns/1ps

module clb_config_bank_bench;
  import clb_pkg::*;
  localparam int SLOT_C [4] = '{8, 16, 2, 4};
  localparam int DEB_C [4] = '{0, DEB_SHORT_CYC, 40, 80};
  localparam int DUTY_L [6] = '{0, 1, 17, 31, 32, 63};
  logic         mclk_in, rst_in, por_rst_in, supply_cmp_raw_in, supply_cmp_out;
  logic         reg_rvalid_out, supply_compare_threshold_out, battery_isolation_switch_open_out;
  logic         charging_in, charger_fault_in, charge_done_in, indicator_led_out, e;
  logic [7:0]   reg_rdata_out, a, v;
  logic [1:0]   supply_compare_debounce_out, indicator_current_out;
  logic [4:0]   k;
  clb_reg_req_t reg_req_in;
  clb_fault_t   fault_in;
  int           failures, check_count, c, per;

  clb_config_bank #(.DEB_MID_CYCLES(DEB_C[2]), .DEB_LONG_CYCLES(DEB_C[3]),
    .SLOT_1HZ_CYCLES(SLOT_C[0]), .SLOT_HALF_CYCLES(SLOT_C[1]),
    .SLOT_256_CYCLES(SLOT_C[2]), .SLOT_8HZ_CYCLES(SLOT_C[3])) DUT (
    .mclk_in(mclk_in), .rst_in(rst_in), .por_rst_in(por_rst_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .supply_cmp_raw_in(supply_cmp_raw_in), .supply_cmp_out(supply_cmp_out),
    .supply_compare_debounce_out(supply_compare_debounce_out),
    .supply_compare_threshold_out(supply_compare_threshold_out), .fault_in(fault_in),
    .battery_isolation_switch_open_out(battery_isolation_switch_open_out),
    .charging_in(charging_in), .charger_fault_in(charger_fault_in),
    .charge_done_in(charge_done_in), .indicator_led_out(indicator_led_out),
    .indicator_current_out(indicator_current_out));
  clb_host HOST (.mclk_in(mclk_in), .reg_req_out(reg_req_in),
    .reg_rdata_in(reg_rdata_out), .reg_rvalid_in(reg_rvalid_out));

  //////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
    logic [7:0] d;
    HOST.rd(ad, d);
    check("rdata", 16'(d), 16'(exp));
  endtask : rd_chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #2;
  endtask : tick
  task automatic do_reset(input logic por);
    if (por) por_rst_in = 1'b1;
    else rst_in = 1'b1;
    tick(1);
    rst_in = 1'b0;
    por_rst_in = 1'b0;
  endtask : do_reset
  // skips two periods less one cycle so a change has settled, then counts one
  task automatic count_on(input int p);
    tick(2 * p - 1);
    c = 0;
    repeat (p) begin
      tick(1);
      c += int'(indicator_led_out === 1'b1);
    end
  endtask : count_on
  function automatic logic exp_open(logic [4:0] kp, clb_fault_t f);
    return |(f & ~{kp[0], kp[1], kp[2], kp[3], kp[4]});
  endfunction : exp_open
  function automatic int exp_on(int duty, int slot);
    return (duty > 32 ? 32 : duty) * slot;
  endfunction : exp_on
  function automatic int exp_fsm(int p, int s, int slot);
    if (s == 2) return 0;
    return ((s == 0) == (p == 0)) ? 32 * slot : 16 * slot;
  endfunction : exp_fsm
  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  //////////////////////////////////////////////////////////////////////
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  initial begin
    #2_000_000;
    failures++;
    $display("watchdog expired");
    complete_run();
  end
  initial begin
    {rst_in, por_rst_in, supply_cmp_raw_in, charging_in, charger_fault_in} = 5'h18;
    charge_done_in = 1'b0;
    fault_in = '0;
    failures = 0;
    check_count = 0;
    c = $urandom(93);
    tick(8);
    rst_in = 1'b0;
    por_rst_in = 1'b0;
    for (int i = 0; i < 6; i++) rd_chk(ADDR_SUPPLY_CMP + 8'(i), 8'h00);
    $display("reset values done");
    repeat (20) begin
      a = ADDR_SUPPLY_CMP + 8'($urandom_range(0, 4));
      v = 8'($urandom);
      HOST.wr(a, v);
      rd_chk(a, v);
      if (a == ADDR_SUPPLY_CMP) check("deb", 16'(supply_compare_debounce_out), 16'(v[1:0]));
      if (a == ADDR_SUPPLY_CMP) check("thr", 16'(supply_compare_threshold_out), 16'(v[2]));
      if (a == ADDR_INDICATOR_BLINK_PATTERN) check("cur", 16'(indicator_current_out), 16'(v[3:2]));
    end
    HOST.wr(8'h40, 8'hA5);
    rd_chk(8'h40, UNMAPPED_READ);
    $display("readback done");
    repeat (16) begin
      k = 5'($urandom);
      HOST.wr(ADDR_FAULT_POLICY, {3'h0, k});
      for (int i = 0; i < 6; i++) begin
        fault_in = clb_fault_t'(i == 5 ? 5'h1F : 5'h01 << i);
        tick(2);
        check("open", 16'(battery_isolation_switch_open_out), 16'(exp_open(k, fault_in)));
      end
      fault_in = '0;
    end
    $display("switch policy done");
    HOST.wr(ADDR_FAULT_POLICY, 8'hFF);
    HOST.wr(ADDR_DUTY_CTL, 8'hFF);
    do_reset(1'b0);
    rd_chk(ADDR_FAULT_POLICY, 8'h10);
    rd_chk(ADDR_DUTY_CTL, 8'h00);
    do_reset(1'b1);
    rd_chk(ADDR_FAULT_POLICY, 8'h00);
    $display("reset source done");
    for (int f = 0; f < 4; f++) begin
      for (int j = 0; j < 7; j++) begin
        per = (j == 6) ? 0 : DUTY_L[j];
        HOST.wr(ADDR_INDICATOR_BLINK_PATTERN, 8'h24 | 8'(f));
        HOST.wr(ADDR_DUTY_CTL, (j == 6 ? 8'h10 : 8'h80) | 8'(per));
        count_on(32 * SLOT_C[f]);
        check("led", 16'(c), 16'(j == 6 ? 0 : exp_on(per, SLOT_C[f])));
      end
    end
    HOST.wr(ADDR_INDICATOR_BLINK_PATTERN, 8'h26);
    HOST.wr(ADDR_DUTY_CTL, 8'h80);
    HOST.wr(ADDR_DUTY_CTL, 8'hC8);
    c = 0;
    repeat (64) @(posedge mclk_in) c += int'(indicator_led_out === 1'b1);
    check("ramp", 16'(c < 16), 16'h1);
    tick(640);
    count_on(64);
    check("ramp", 16'(c), 16'(exp_on(8, 2)));
    $display("software led done");
    HOST.wr(ADDR_DUTY_CTL, 8'h00);
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 3; s++) begin
        HOST.wr(ADDR_INDICATOR_BLINK_PATTERN, 8'h06 | 8'(p << 4));
        {charging_in, charger_fault_in, charge_done_in} = {s != 1, s == 1, s == 2};
        count_on(64);
        check("led", 16'(c), 16'(exp_fsm(p, s, 2)));
      end
    end
    $display("charger led done");
    e = 1'b0;
    for (int cd = 1; cd < 5; cd++) begin
      HOST.wr(ADDR_SUPPLY_CMP, 8'(cd % 4));
      supply_cmp_raw_in = ~supply_cmp_raw_in;
      tick(cd == 4 ? 200 : DEB_C[cd] - 3);
      check("cmp", 16'(supply_cmp_out), 16'(e));
      if (cd < 4) e = ~e;
      tick(10);
      check("cmp", 16'(supply_cmp_out), 16'(e));
    end
    $display("debounce done");
    complete_run();
  end
endmodule : clb_config_bank_bench
